// file: logic/acc_defines.svh
// Register offsets, field positions, reset values and timing for the comparator control block
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH

// Register indices; the byte address is four times the index
`define ACC_IDX_BUF_DIS 6'h0d
`define ACC_IDX_CTRL_A 6'h10
`define ACC_IDX_CTRL_B 6'h13
`define ACC_IDX_IRQ_STAT 6'h14
`define ACC_IDX_IRQ_MASK 6'h15
`define ACC_IDX_CORE 6'h16

// Control/status A field positions
`define ACC_A_POWER_OFF 7
`define ACC_A_POS_REF 6
`define ACC_A_SYNC_OUT 5
`define ACC_A_FLAG 4
`define ACC_A_IRQ_EN 3
`define ACC_A_ROUTE 2

// Control B field positions
`define ACC_B_HYST_EN 7
`define ACC_B_HYST_LEVEL 6
`define ACC_B_RESERVED 4
`define ACC_B_MUX_EN 2

// Core register: bit 0 acknowledges the interrupt vector when written with one
`define ACC_CORE_VEC_ACK 0

// Reset values
`define ACC_RST_BYTE 8'h00
`define ACC_RST_WORD 32'h0000_0000

// Synchroniser latency in clock cycles
`define ACC_SYNC_STAGES 2

`endif

// file: logic/acc_pkg.sv
// Types for the comparator control block
package acc_pkg;

  // Interrupt mode field encoding
  typedef enum logic [1:0] {
    ACC_MODE_TOGGLE = 2'h0,
    ACC_MODE_RESERVED = 2'h1,
    ACC_MODE_FALL = 2'h2,
    ACC_MODE_RISE = 2'h3
  } acc_mode_t;

  // Control/status A layout
  typedef struct packed {
    logic comparator_power_off;
    logic positive_reference_select;
    logic synced_compare_result;
    logic compare_event_flag;
    logic compare_irq_enable;
    logic capture_route_enable;
    acc_mode_t compare_event_mode;
  } acc_ctrl_a_t;

  // Control B layout
  typedef struct packed {
    logic hysteresis_enable;
    logic hysteresis_level;
    logic touch_reserved_5;
    logic reserved_4;
    logic touch_reserved_3;
    logic negative_input_mux_enable;
    logic touch_reserved_1;
    logic touch_reserved_0;
  } acc_ctrl_b_t;

  // Settings sent to the analog core
  typedef struct packed {
    logic power_off;
    logic positive_reference_select;
    logic hysteresis_enable;
    logic hysteresis_level;
    logic negative_from_mux;
    logic [3:0] negative_channel;
  } acc_analog_t;

  // Bus handshake states
  typedef enum logic [1:0] {
    ACC_BUS_IDLE = 2'b01,
    ACC_BUS_ACK = 2'b10
  } acc_bus_state_t;

endpackage : acc_pkg

// file: logic/acc_top.sv
// Comparator control, status, interrupt and register logic
// Operation
// R1 - Disable bit powers the comparator down
// R2 - Software clears irq enable before disable change
// R3 - Bandgap bit selects internal reference, else pin
// R4 - Comparator output synchronised, readable as status
// R5 - Flag set on selected output event
// R6 - Flag cleared by vector or write-one
// R7 - Request needs flag, enable and global enable
// R8 - Route bit feeds output to capture
// R9 - Route clear disconnects capture; timer enable needed
// R10 - Mode: toggle, reserved, falling, rising edges
// R11 - Software clears irq enable before mode change
// R12 - Control B resets zero, bit 4 reads zero
// R13 - Control B drives hysteresis enable and level
// R14 - Software writes zero to touch bits
// R15 - Mux enable with converter off selects mux
// R16 - Buffer disable bits gate pin inputs
// R17 - Channel field picks mux negative input
// R18 - Edges found by comparing with previous sample
`timescale 1ns/1ps
`default_nettype none
`include "acc_defines.svh"

module acc_top
  import acc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] avs_address,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic compare_raw,
  input wire logic converter_enable,
  input wire logic [3:0] channel_select_field,
  input wire logic global_irq_enable,
  input wire logic vector_ack,
  input wire logic [7:0] pin_raw,
  output acc_analog_t analog_ctrl,
  output logic [7:0] buffer_off,
  output logic [7:0] port_input,
  output logic capture_input,
  output logic compare_irq_req,
  output logic irq
);

  acc_bus_state_t bus_state_r;
  acc_ctrl_a_t ctrl_a_r;
  acc_ctrl_b_t ctrl_b_r;
  logic [7:0] buf_dis_r;
  logic irq_stat_r;
  logic irq_mask_r;
  logic cmp_meta_r;
  logic cmp_sync_r;
  logic cmp_prev_r;
  logic [7:0] pin_meta_r;
  logic [7:0] pin_sync_r;
  logic [31:0] rdata_nxt;
  logic [5:0] reg_idx;
  logic wr_take;
  logic wr_lane;
  logic evt;
  logic rise;
  logic fall;
  logic flag_w1c;
  logic stat_w1c;
  logic vec_w1;

  // Bus decode; a write takes effect on the edge where waitrequest is low
  assign reg_idx = avs_address[7:2];
  assign wr_take = avs_write && (bus_state_r == ACC_BUS_ACK);
  assign wr_lane = wr_take && avs_byteenable[0];
  assign flag_w1c = wr_lane && (reg_idx == `ACC_IDX_CTRL_A) &&
                    avs_writedata[`ACC_A_FLAG];
  assign stat_w1c = wr_lane && (reg_idx == `ACC_IDX_IRQ_STAT) && avs_writedata[0];
  assign vec_w1 = wr_lane && (reg_idx == `ACC_IDX_CORE) &&
                  avs_writedata[`ACC_CORE_VEC_ACK];

  // Bus handshake: one idle cycle, then one answer cycle with waitrequest low
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bus_state_r <= ACC_BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      case (bus_state_r)
        ACC_BUS_IDLE:
        begin
          if (avs_read || avs_write)
          begin
            bus_state_r <= ACC_BUS_ACK;
            avs_waitrequest <= 1'b0;
          end
        end
        ACC_BUS_ACK:
        begin
          bus_state_r <= ACC_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default:
        begin
          bus_state_r <= ACC_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // Read mux; unmapped addresses and upper bits read zero
  always_comb
  begin
    rdata_nxt = `ACC_RST_WORD;
    case (reg_idx)
      `ACC_IDX_BUF_DIS: rdata_nxt[7:0] = buf_dis_r;
      `ACC_IDX_CTRL_A: rdata_nxt[7:0] = ctrl_a_r;
      `ACC_IDX_CTRL_B: rdata_nxt[7:0] = ctrl_b_r;
      `ACC_IDX_IRQ_STAT: rdata_nxt[0] = irq_stat_r;
      `ACC_IDX_IRQ_MASK: rdata_nxt[0] = irq_mask_r;
      default: rdata_nxt = `ACC_RST_WORD;
    endcase
  end

  // Read data is captured with the answer and held until the next read request
  always_ff @(posedge clk)
  begin
    if (rst)
      avs_readdata <= `ACC_RST_WORD;
    else if (avs_read && bus_state_r == ACC_BUS_IDLE)
      avs_readdata <= rdata_nxt;
  end

  // First synchroniser stage and previous sample; the second stage is the status bit
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmp_meta_r <= 1'b0;
      cmp_prev_r <= 1'b0;
    end
    else
    begin
      cmp_meta_r <= compare_raw;
      cmp_prev_r <= cmp_sync_r; // R18
    end
  end

  // Second stage lives in control/status A, so software sees it with no extra flop
  assign cmp_sync_r = ctrl_a_r.synced_compare_result; // R4

  // Edge events, selected by the mode field; the reserved code gives none
  assign rise = cmp_sync_r && !cmp_prev_r; // R18
  assign fall = !cmp_sync_r && cmp_prev_r; // R18
  always_comb
  begin
    case (ctrl_a_r.compare_event_mode) // R10
      ACC_MODE_TOGGLE: evt = rise || fall;
      ACC_MODE_FALL: evt = fall;
      ACC_MODE_RISE: evt = rise;
      default: evt = 1'b0;
    endcase
  end

  // Control/status A in one process: writable fields, status stage and event flag
  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl_a_r <= `ACC_RST_BYTE;
    else
    begin
      // Second synchroniser stage, read back as the status bit
      ctrl_a_r.synced_compare_result <= cmp_meta_r; // R4
      if (wr_lane && reg_idx == `ACC_IDX_CTRL_A)
      begin
        ctrl_a_r.comparator_power_off <= avs_writedata[`ACC_A_POWER_OFF]; // R1
        ctrl_a_r.positive_reference_select <= avs_writedata[`ACC_A_POS_REF]; // R3
        ctrl_a_r.compare_irq_enable <= avs_writedata[`ACC_A_IRQ_EN]; // R7
        ctrl_a_r.capture_route_enable <= avs_writedata[`ACC_A_ROUTE]; // R8
        ctrl_a_r.compare_event_mode <= acc_mode_t'(avs_writedata[1:0]); // R10
      end
      // Event flag: a set wins over vector or write-one clear
      if (evt)
        ctrl_a_r.compare_event_flag <= 1'b1; // R5
      else if (vector_ack || vec_w1 || flag_w1c)
        ctrl_a_r.compare_event_flag <= 1'b0; // R6
    end
  end

  // Control B; reserved bit 4 stays zero
  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl_b_r <= `ACC_RST_BYTE; // R12
    else if (wr_lane && reg_idx == `ACC_IDX_CTRL_B)
    begin
      ctrl_b_r <= avs_writedata[7:0];
      ctrl_b_r.reserved_4 <= 1'b0; // R12
    end
  end

  // Digital input buffer disable
  always_ff @(posedge clk)
  begin
    if (rst)
      buf_dis_r <= `ACC_RST_BYTE; // R16
    else if (wr_lane && reg_idx == `ACC_IDX_BUF_DIS)
      buf_dis_r <= avs_writedata[7:0];
  end

  // Sticky status, cleared by write-one; a new event wins
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_stat_r <= 1'b0;
    else if (evt)
      irq_stat_r <= 1'b1;
    else if (stat_w1c)
      irq_stat_r <= 1'b0;
  end

  // Interrupt mask
  always_ff @(posedge clk)
  begin
    if (rst)
      irq_mask_r <= 1'b0;
    else if (wr_lane && reg_idx == `ACC_IDX_IRQ_MASK)
      irq_mask_r <= avs_writedata[0];
  end

  // Interrupt outputs
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      irq <= 1'b0;
      compare_irq_req <= 1'b0;
    end
    else
    begin
      irq <= irq_stat_r && irq_mask_r;
      compare_irq_req <= ctrl_a_r.compare_event_flag &&
                         ctrl_a_r.compare_irq_enable && global_irq_enable; // R7
    end
  end

  // Settings to the analog core and the capture path
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      analog_ctrl <= '0;
      capture_input <= 1'b0;
    end
    else
    begin
      analog_ctrl.power_off <= ctrl_a_r.comparator_power_off; // R1
      analog_ctrl.positive_reference_select <= ctrl_a_r.positive_reference_select; // R3
      analog_ctrl.hysteresis_enable <= ctrl_b_r.hysteresis_enable; // R13
      analog_ctrl.hysteresis_level <= ctrl_b_r.hysteresis_level; // R13
      analog_ctrl.negative_from_mux <= ctrl_b_r.negative_input_mux_enable &&
                                       !converter_enable; // R15
      analog_ctrl.negative_channel <= channel_select_field; // R17
      capture_input <= ctrl_a_r.capture_route_enable && cmp_sync_r; // R8 R9
    end
  end

  // Pin synchroniser and digital input gating
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin_meta_r <= `ACC_RST_BYTE;
      pin_sync_r <= `ACC_RST_BYTE;
      port_input <= `ACC_RST_BYTE;
      buffer_off <= `ACC_RST_BYTE;
    end
    else
    begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
      port_input <= pin_sync_r & ~buf_dis_r; // R16
      buffer_off <= buf_dis_r; // R16
    end
  end

  // Checks on the synchroniser, flag, interrupt, analog and bus paths
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_sync_latency: assert property (##3 cmp_sync_r == $past(compare_raw, 2)) // R4
    else $error("Synchronised output not two cycles behind input");
  a_status_mirror: assert property (avs_read && !avs_waitrequest // R4
      && reg_idx == `ACC_IDX_CTRL_A |-> avs_readdata[`ACC_A_SYNC_OUT] == $past(cmp_sync_r))
    else $error("Status bit read does not show synchronised output");
  a_flag_set: assert property (evt |=> ctrl_a_r.compare_event_flag) // R5
    else $error("Event did not set flag");
  a_flag_clear: assert property ((vector_ack || flag_w1c) && !evt // R6
      |=> !ctrl_a_r.compare_event_flag)
    else $error("Flag not cleared");
  a_core_ack: assert property (vec_w1 && !evt |=> !ctrl_a_r.compare_event_flag) // R6
    else $error("Core write did not clear flag");
  a_irq_request: assert property (compare_irq_req |-> $past(ctrl_a_r.compare_event_flag) // R7
      && $past(ctrl_a_r.compare_irq_enable) && $past(global_irq_enable))
    else $error("Request without flag and enables");
  a_irq_out: assert property (##1 irq == ($past(irq_stat_r) && $past(irq_mask_r)))
    else $error("Interrupt output not status and mask");
  a_mode_edges: assert property (ctrl_a_r.compare_event_mode == ACC_MODE_RISE && evt // R10
      |-> cmp_sync_r && !cmp_prev_r)
    else $error("Rising mode fired on other edge");
  a_mode_reserved: assert property (ctrl_a_r.compare_event_mode == ACC_MODE_RESERVED // R10
      |-> !evt)
    else $error("Reserved mode produced event");
  a_route_off: assert property (!ctrl_a_r.capture_route_enable |=> !capture_input) // R9
    else $error("Capture driven while route off");
  a_route_on: assert property (ctrl_a_r.capture_route_enable // R8
      |=> capture_input == $past(cmp_sync_r))
    else $error("Capture input not following comparator");
  a_power_ref: assert property (##1 // R1 R3
      analog_ctrl.power_off == $past(ctrl_a_r.comparator_power_off)
      && analog_ctrl.positive_reference_select == $past(ctrl_a_r.positive_reference_select))
    else $error("Power or reference select mismatch");
  a_b_reserved: assert property (!ctrl_b_r.reserved_4) // R12
    else $error("Reserved bit of control B set");
  a_hyst: assert property (##1 // R13
      analog_ctrl.hysteresis_enable == $past(ctrl_b_r.hysteresis_enable)
      && analog_ctrl.hysteresis_level == $past(ctrl_b_r.hysteresis_level))
    else $error("Hysteresis settings mismatch");
  a_mux_select: assert property (converter_enable |=> !analog_ctrl.negative_from_mux) // R15
    else $error("Mux selected while converter on");
  a_mux_channel: assert property (##1 // R17
      analog_ctrl.negative_channel == $past(channel_select_field))
    else $error("Channel not forwarded");
  a_pin_gate: assert property (##1 (port_input & $past(buf_dis_r)) == 8'h00) // R16
    else $error("Disabled pin reads one");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest
      ##1 avs_waitrequest)
    else $error("Bus answer not one cycle after request");

endmodule : acc_top

`default_nettype wire

// file: test/acc_cmp_model.sv
// Comparator core and timer capture model
`timescale 1ns/1ps
`default_nettype none
module acc_cmp_model
  import acc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic level,
  input wire logic timer_capture_irq_enable,
  input wire acc_analog_t analog_ctrl,
  input wire logic capture_input,
  output logic compare_raw,
  output logic [7:0] cap_cnt
);
  logic cap_d_r;
  // A powered-off core holds its output low
  assign compare_raw = analog_ctrl.power_off ? 1'b0 : level;
  // Timer counts capture rises only with its own enable set
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cap_d_r <= 1'b0;
      cap_cnt <= 8'h00;
    end
    else
    begin
      cap_d_r <= capture_input;
      if (capture_input && !cap_d_r && timer_capture_irq_enable)
        cap_cnt <= cap_cnt + 8'h01;
    end
  end
endmodule : acc_cmp_model
`default_nettype wire

// file: test/test_acc_top.sv
// Bench for the comparator control block
`timescale 1ns/1ps
`default_nettype none
`include "acc_defines.svh"
module test_acc_top
  import acc_pkg::*;
;
  localparam logic [7:0] AA = {`ACC_IDX_CTRL_A, 2'b00};
  localparam logic [7:0] AB = {`ACC_IDX_CTRL_B, 2'b00};
  localparam logic [7:0] AD = {`ACC_IDX_BUF_DIS, 2'b00};
  localparam logic [7:0] AS = {`ACC_IDX_IRQ_STAT, 2'b00};
  localparam logic [7:0] AM = {`ACC_IDX_IRQ_MASK, 2'b00};
  localparam logic [7:0] AC = {`ACC_IDX_CORE, 2'b00};
  logic clk, rst, avs_read, avs_write, avs_waitrequest, compare_raw, converter_enable;
  logic global_irq_enable, vector_ack, capture_input, compare_irq_req, irq, level, cap_en;
  logic [7:0] avs_address, pin_raw, buffer_off, port_input, cap_cnt, b, d, p, q;
  logic [3:0] avs_byteenable, channel_select_field;
  logic [31:0] avs_writedata, avs_readdata;
  acc_analog_t analog_ctrl;
  integer err_total, samples_checked, seed, i, m;

  acc_top acc_top_i (.clk(clk), .rst(rst), .avs_address(avs_address),
    .avs_byteenable(avs_byteenable), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .compare_raw(compare_raw),
    .converter_enable(converter_enable), .channel_select_field(channel_select_field),
    .global_irq_enable(global_irq_enable), .vector_ack(vector_ack), .pin_raw(pin_raw),
    .analog_ctrl(analog_ctrl), .buffer_off(buffer_off), .port_input(port_input),
    .capture_input(capture_input), .compare_irq_req(compare_irq_req), .irq(irq));
  acc_cmp_model acc_cmp_model_i (.clk(clk), .rst(rst), .level(level),
    .timer_capture_irq_enable(cap_en), .analog_ctrl(analog_ctrl),
    .capture_input(capture_input), .compare_raw(compare_raw), .cap_cnt(cap_cnt));

  // Closing report and verdict
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  // Compare seen against expected
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string t);
    samples_checked++;
    if (s !== e)
    begin
      err_total++;
      $display("mismatch at %0t: %s seen %h exp %h", $time, t, s, e);
    end
  endtask : chk

  // One bus transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] wd);
    integer n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, wd};
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0)
    begin
      err_total++;
      conclude();
    end
    else
    begin
      q = avs_readdata[7:0];
      avs_read <= 1'b0;
      avs_write <= 1'b0;
    end
  endtask : bus

  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string t);
    bus(1'b0, a, 8'h00);
    chk({24'h0, q}, {24'h0, e}, t);
  endtask : rdc

  // Expected flag for a mode and an edge direction
  function automatic logic ev(input integer md, input logic rise);
    return md == 0 || (md == 3 && rise) || (md == 2 && !rise);
  endfunction : ev

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    conclude();
  end

  // Main sequence
  initial
  begin
    seed = 32'he101;
    err_total = 0;
    samples_checked = 0;
    rst = 1'b1;
    {avs_read, avs_write, vector_ack, global_irq_enable, level, cap_en} = 6'h00;
    converter_enable = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    channel_select_field = 4'h0;
    pin_raw = 8'h00;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rdc(AD, 8'h00, "buf rst");
    rdc(AB, 8'h00, "b rst");
    rdc(AA, 8'h00, "a rst");
    bus(1'b1, 8'h00, 8'hff);
    rdc(8'h00, 8'h00, "unmapped");
    avs_byteenable <= 4'he;
    bus(1'b1, AD, 8'h5a);
    avs_byteenable <= 4'hf;
    rdc(AD, 8'h00, "lane off");
    $display("reset test done");
    for (i = 0; i < 8; i++)
    begin
      b = 8'($random(seed)) & 8'hd4;
      m = (($random(seed)) & 32'hff) % 12;
      d = 8'($random(seed));
      p = 8'($random(seed));
      converter_enable <= d[3];
      channel_select_field <= m[3:0];
      bus(1'b1, AB, b);
      bus(1'b1, AD, d);
      pin_raw <= p;
      repeat (4) @(posedge clk);
      chk({23'h0, analog_ctrl}, {25'h0, b[7:6], b[2] & ~d[3], m[3:0]}, "analog");
      rdc(AB, b & 8'hef, "b read");
      chk({24'h0, port_input}, {24'h0, p & ~d}, "port");
      chk({24'h0, buffer_off}, {24'h0, d}, "buf");
      rdc(AD, d, "buf read");
    end
    bus(1'b1, AA, 8'hc0);
    repeat (2) @(posedge clk);
    level <= 1'b1;
    repeat (6) @(posedge clk);
    chk({31'h0, analog_ctrl.power_off}, 32'h1, "power");
    chk({31'h0, analog_ctrl.positive_reference_select}, 32'h1, "ref");
    rdc(AA, 8'hc0, "off out");
    bus(1'b1, AA, 8'h10);
    level <= 1'b0;
    bus(1'b1, AS, 8'h01);
    $display("config test done");
    for (m = 0; m < 4; m++)
    begin
      d = {6'h0, m[1:0]};
      bus(1'b1, AA, d);
      for (i = 0; i < 2; i++)
      begin
        level <= ~i[0];
        repeat (6) @(posedge clk);
        rdc(AA, d | {2'b0, ~i[0], ev(m, ~i[0]), 4'h0}, "event");
        bus(1'b1, AA, d | 8'h10);
        rdc(AA, d | {2'b0, ~i[0], 5'h0}, "w1c");
      end
    end
    $display("mode test done");
    bus(1'b1, AS, 8'h01);
    bus(1'b1, AM, 8'h01);
    global_irq_enable <= 1'b1;
    bus(1'b1, AA, 8'h08);
    level <= 1'b1;
    repeat (8) @(posedge clk);
    chk({30'h0, compare_irq_req, irq}, 32'h3, "req");
    vector_ack <= 1'b1;
    @(posedge clk);
    vector_ack <= 1'b0;
    repeat (3) @(posedge clk);
    chk({31'h0, compare_irq_req}, 32'h0, "vector");
    bus(1'b1, AM, 8'h00);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0, "mask");
    rdc(AS, 8'h01, "stat");
    bus(1'b1, AS, 8'h01);
    rdc(AS, 8'h00, "stat w1c");
    global_irq_enable <= 1'b0;
    level <= 1'b0;
    repeat (8) @(posedge clk);
    chk({31'h0, compare_irq_req}, 32'h0, "global");
    global_irq_enable <= 1'b1;
    repeat (3) @(posedge clk);
    chk({31'h0, compare_irq_req}, 32'h1, "global on");
    bus(1'b1, AA, 8'h00);
    repeat (3) @(posedge clk);
    chk({31'h0, compare_irq_req}, 32'h0, "en off");
    bus(1'b1, AC, 8'h01);
    rdc(AA, 8'h00, "core ack");
    bus(1'b1, AA, 8'h10);
    $display("irq test done");
    cap_en <= 1'b1;
    bus(1'b1, AA, 8'h04);
    level <= 1'b1;
    repeat (6) @(posedge clk);
    chk({31'h0, capture_input}, 32'h1, "route");
    chk({24'h0, cap_cnt}, 32'h1, "count");
    bus(1'b1, AA, 8'h00);
    repeat (3) @(posedge clk);
    chk({31'h0, capture_input}, 32'h0, "unroute");
    $display("route test done");
    conclude();
  end
endmodule : test_acc_top
`default_nettype wire
